// [pkg/fifo_link_pkg.sv]
// Purpose: Shared constants, types and helpers for the mailbox FIFO link
// Assumes: One clock at 250 MHz for both ends
// Notes: Port B width selects how a long word is split into pieces
`default_nettype none
package fifo_link_pkg;
  localparam int LONG_W = 36;
  localparam int WORD_W = 18;
  localparam int BYTE_W = 9;
  localparam int DEPTH_DEFAULT = 1024;
  localparam int BUF_DEPTH_DEFAULT = 32;
  localparam int AE_OFFSET_DEFAULT = 8;
  localparam int AF_OFFSET_DEFAULT = 8;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int RECOVERY_TIME_NS = 90;
  localparam int RECOVERY_CYCLES = (RECOVERY_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FLAG_SETTLE_CYCLES = 2;
  localparam int RT_LOW_CYCLES = 2;
  localparam int RT_CNT_W = 8;

  typedef enum logic [1:0] {
    SIZE_LONG = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_BYTE = 2'h2
  } port_size_t;

  // Index of the last piece of a long word
  function automatic logic [1:0] last_piece(input port_size_t s);
    case (s)
      SIZE_WORD: last_piece = 2'h1;
      SIZE_BYTE: last_piece = 2'h3;
      default: last_piece = 2'h0;
    endcase
  endfunction

  // One piece of a long word, low bits first, upper bits zero
  function automatic logic [LONG_W-1:0] piece(input logic [LONG_W-1:0] d, input port_size_t s,
                                             input logic [1:0] idx);
    piece = d;
    case (s)
      SIZE_WORD: piece = {18'h0, (idx[0] ? d[35:18] : d[17:0])};
      SIZE_BYTE: begin
        case (idx)
          2'h0: piece = {27'h0, d[8:0]};
          2'h1: piece = {27'h0, d[17:9]};
          2'h2: piece = {27'h0, d[26:18]};
          default: piece = {27'h0, d[35:27]};
        endcase
      end
      default: piece = d;
    endcase
  endfunction
endpackage
`default_nettype wire

// [pkg/fifo_link_if.sv]
// Purpose: Pin-level link between the FIFO device and its two port users
// Assumes: Both ends on clk
// Notes: Separate in and out data buses, no shared wires
`timescale 1ns/1ps
`default_nettype none
interface fifo_link_if;
  // Port A
  logic input_port_select_n;
  logic input_port_direction;
  logic input_mailbox_select;
  logic [35:0] a_wr_data;
  logic [35:0] a_rd_data;
  // Port B
  logic output_port_select_n;
  logic output_port_direction;
  logic output_mailbox_select;
  logic [35:0] b_wr_data;
  logic [35:0] b_rd_data;
  // Control
  logic master_reset_n;
  logic partial_reset_n;
  logic retransmit_req_n;
  logic fall_through_mode;
  fifo_link_pkg::port_size_t port_b_size;
  // Flags
  logic full_or_in_ready;
  logic empty_or_out_ready;
  logic almost_empty_n;
  logic almost_full_n;
  logic fwd_mail_flag_n;
  logic back_mail_flag_n;

  modport dev (
    input input_port_select_n, input_port_direction, input_mailbox_select, a_wr_data,
    input output_port_select_n, output_port_direction, output_mailbox_select, b_wr_data,
    input master_reset_n, partial_reset_n, retransmit_req_n, fall_through_mode, port_b_size,
    output a_rd_data, b_rd_data, full_or_in_ready, empty_or_out_ready,
    output almost_empty_n, almost_full_n, fwd_mail_flag_n, back_mail_flag_n
  );
  modport host (
    output input_port_select_n, input_port_direction, input_mailbox_select, a_wr_data,
    output output_port_select_n, output_port_direction, output_mailbox_select, b_wr_data,
    output master_reset_n, partial_reset_n, retransmit_req_n, fall_through_mode, port_b_size,
    input a_rd_data, b_rd_data, full_or_in_ready, empty_or_out_ready,
    input almost_empty_n, almost_full_n, fwd_mail_flag_n, back_mail_flag_n
  );
endinterface
`default_nettype wire

// [hdl/fifo_device_end.sv]
// Purpose: FIFO device end with flags, two mailboxes and retransmit
// Assumes: One clock; port users obey write blackout around retransmit
// Notes: Flags are registered from the next occupancy, so they lag by one edge
// Behaviour
// - Port A write needs select low, direction high, mailbox low
// - Port B read needs select low, direction high, mailbox low
// - Memory depth parameter: 1K, 4K or 16K
// - Narrow port: almost-empty falls on last piece
// - Almost-empty rises next cycle after write
// - Almost-full rises next cycle after read
// - Forward mailbox keeps bits 0-17 or 0-8
// - Back mailbox keeps bits 0-17 or 0-8
// - Retransmit only in standard mode, clocks running
// - Writer idles around retransmit and recovery
// - Empty/full may toggle during retransmit
// - Almost flags update two cycles after recovery
// - Writes since reset below depth minus 2/4/8
// - Resets force all flags to initial levels
// - Mailbox write clears flag, read sets it
// - Port B mailbox select shows forward mail
`timescale 1ns/1ps
`default_nettype none
module fifo_buffer #(
  parameter int WIDTH = fifo_link_pkg::LONG_W,
  parameter int DEPTH = fifo_link_pkg::BUF_DEPTH_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic rewind,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } buf_state_t;
  buf_state_t st_ff;
  buf_state_t nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];

  assign count = st_ff.wr_ptr - st_ff.rd_ptr;
  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[st_ff.rd_ptr[AW-1:0]];

  always_comb begin
    nxt_st = st_ff;
    if (in_valid && in_ready) begin
      nxt_st.wr_ptr = st_ff.wr_ptr + 1'b1;
    end
    if (rewind) begin
      nxt_st.rd_ptr = '0;
    end else if (out_valid && out_ready) begin
      nxt_st.rd_ptr = st_ff.rd_ptr + 1'b1;
    end
    if (flush) begin
      nxt_st = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      mem[st_ff.wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

module fifo_device_end #(
  parameter int DEPTH = fifo_link_pkg::DEPTH_DEFAULT,
  parameter int AE_OFFSET = fifo_link_pkg::AE_OFFSET_DEFAULT,
  parameter int AF_OFFSET = fifo_link_pkg::AF_OFFSET_DEFAULT
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link
  fifo_link_if.dev link
);
  localparam int CW = $clog2(DEPTH) + 1;
  localparam logic [fifo_link_pkg::RT_CNT_W-1:0] RT_HOLD =
    fifo_link_pkg::RT_CNT_W'(fifo_link_pkg::RECOVERY_CYCLES + fifo_link_pkg::FLAG_SETTLE_CYCLES);

  typedef struct packed {
    logic [35:0] fwd_mail;
    logic [35:0] back_mail;
    logic fwd_flag_n;
    logic back_flag_n;
    logic [35:0] a_out;
    logic [35:0] b_out;
    logic [1:0] sub;
    logic ae_n;
    logic af_n;
    logic ef;
    logic ff;
    logic rt_low;
    logic [fifo_link_pkg::RT_CNT_W-1:0] rt_cnt;
  } dev_state_t;

  dev_state_t st_ff;
  dev_state_t nxt_st;

  logic flush;
  logic rt_active;
  logic wr_fifo;
  logic rd_fifo;
  logic a_mail_wr;
  logic a_mail_rd;
  logic b_mail_rd;
  logic b_mail_wr;
  logic buf_in_ready;
  logic buf_out_valid;
  logic pop;
  logic push;
  logic [35:0] head;
  logic [CW-1:0] count;
  logic [CW-1:0] cnt_next;

  assign flush = !link.master_reset_n || !link.partial_reset_n;
  assign rt_active = !link.retransmit_req_n && !link.fall_through_mode;
  assign wr_fifo = !link.input_port_select_n && link.input_port_direction
                   && !link.input_mailbox_select;
  assign rd_fifo = !link.output_port_select_n && link.output_port_direction
                   && !link.output_mailbox_select;
  assign a_mail_wr = !link.input_port_select_n && link.input_port_direction
                     && link.input_mailbox_select;
  assign a_mail_rd = !link.input_port_select_n && !link.input_port_direction
                     && link.input_mailbox_select;
  assign b_mail_rd = !link.output_port_select_n && link.output_port_direction
                     && link.output_mailbox_select;
  assign b_mail_wr = !link.output_port_select_n && !link.output_port_direction
                     && link.output_mailbox_select;

  // Long word leaves memory only on its last piece
  assign push = wr_fifo && buf_in_ready;
  assign pop = rd_fifo && buf_out_valid && !rt_active
               && (st_ff.sub == fifo_link_pkg::last_piece(link.port_b_size));
  assign cnt_next = count + CW'(push) - CW'(pop);

  fifo_buffer #(
    .WIDTH(fifo_link_pkg::LONG_W),
    .DEPTH(DEPTH)
  ) u_buf (
    .clk(clk),
    .nrst(nrst),
    .flush(flush),
    .rewind(rt_active),
    .in_valid(wr_fifo),
    .in_ready(buf_in_ready),
    .in_data(link.a_wr_data),
    .out_valid(buf_out_valid),
    .out_ready(pop),
    .out_data(head),
    .count(count)
  );

  always_comb begin
    nxt_st = st_ff;
    // Occupancy flags track the pointers, retransmit included
    nxt_st.ef = (cnt_next != '0);
    nxt_st.ff = (cnt_next != CW'(DEPTH));
    nxt_st.rt_low = rt_active;
    if (rt_active) begin
      nxt_st.rt_cnt = RT_HOLD;
      nxt_st.sub = 2'h0;
    end else if (st_ff.rt_cnt != '0) begin
      nxt_st.rt_cnt = st_ff.rt_cnt - 1'b1;
    end
    if (!rt_active && !st_ff.rt_low && st_ff.rt_cnt == '0) begin
      nxt_st.ae_n = (cnt_next > CW'(AE_OFFSET));
      nxt_st.af_n = ((CW'(DEPTH) - cnt_next) > CW'(AF_OFFSET));
    end
    // Port B read path and port A mail read
    if (rd_fifo && buf_out_valid && !rt_active) begin
      nxt_st.b_out = fifo_link_pkg::piece(head, link.port_b_size, st_ff.sub);
      nxt_st.sub = pop ? 2'h0 : st_ff.sub + 1'b1;
    end else if (b_mail_rd) begin
      nxt_st.b_out = st_ff.fwd_mail;
    end
    if (a_mail_rd) begin
      nxt_st.a_out = st_ff.back_mail;
    end
    // Mailboxes, a new write wins over a same-cycle read
    if (b_mail_rd) begin
      nxt_st.fwd_flag_n = 1'b1;
    end
    if (a_mail_wr) begin
      nxt_st.fwd_mail = fifo_link_pkg::piece(link.a_wr_data, link.port_b_size, 2'h0);
      nxt_st.fwd_flag_n = 1'b0;
    end
    if (a_mail_rd) begin
      nxt_st.back_flag_n = 1'b1;
    end
    if (b_mail_wr) begin
      nxt_st.back_mail = fifo_link_pkg::piece(link.b_wr_data, link.port_b_size, 2'h0);
      nxt_st.back_flag_n = 1'b0;
    end
    if (flush) begin
      nxt_st.ae_n = 1'b0;
      nxt_st.af_n = 1'b1;
      nxt_st.ef = 1'b0;
      nxt_st.ff = 1'b0;
      nxt_st.fwd_flag_n = 1'b1;
      nxt_st.back_flag_n = 1'b1;
      nxt_st.sub = 2'h0;
      nxt_st.rt_cnt = '0;
      nxt_st.rt_low = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.af_n <= 1'b1;
      st_ff.fwd_flag_n <= 1'b1;
      st_ff.back_flag_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign link.a_rd_data = st_ff.a_out;
  assign link.b_rd_data = st_ff.b_out;
  assign link.full_or_in_ready = st_ff.ff;
  assign link.empty_or_out_ready = st_ff.ef;
  assign link.almost_empty_n = st_ff.ae_n;
  assign link.almost_full_n = st_ff.af_n;
  assign link.fwd_mail_flag_n = st_ff.fwd_flag_n;
  assign link.back_mail_flag_n = st_ff.back_flag_n;
endmodule
`default_nettype wire

// [hdl/fifo_host_end.sv]
// Purpose: Port users of the FIFO device: writer on port A, reader on port B
// Assumes: Same clock as the device; flags read directly
// Notes: Each narrow piece read on port B is delivered as one recv item
`timescale 1ns/1ps
`default_nettype none
module fifo_host_end (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration
  input wire fifo_link_pkg::port_size_t port_size,
  input wire logic fall_through,
  input wire logic flush_req,
  input wire logic retransmit_start,
  output logic retransmit_busy,
  // Stream into the FIFO
  input wire logic send_valid,
  output logic send_ready,
  input wire logic [35:0] send_data,
  // Stream out of the FIFO
  output logic recv_valid,
  input wire logic recv_ready,
  output logic [35:0] recv_data,
  // Forward mail, A to B
  input wire logic fwd_tx_valid,
  output logic fwd_tx_ready,
  input wire logic [35:0] fwd_tx_data,
  output logic fwd_rx_valid,
  output logic [35:0] fwd_rx_data,
  // Back mail, B to A
  input wire logic back_tx_valid,
  output logic back_tx_ready,
  input wire logic [35:0] back_tx_data,
  output logic back_rx_valid,
  output logic [35:0] back_rx_data,
  // Link
  fifo_link_if.host link
);
  typedef enum logic [1:0] {
    RT_IDLE = 2'b00,
    RT_GUARD = 2'b01,
    RT_LOW = 2'b10,
    RT_RECOVER = 2'b11
  } rt_state_t;

  typedef struct packed {
    rt_state_t rt;
    logic [fifo_link_pkg::RT_CNT_W-1:0] rt_cnt;
    logic fwd_pend;
    logic [35:0] fwd_data;
    logic back_pend;
    logic [35:0] back_data;
    logic rd_cap;
    logic fwd_cap;
    logic back_cap;
    logic recv_v;
    logic [35:0] recv_d;
    logic fwd_rx_v;
    logic [35:0] fwd_rx_d;
    logic back_rx_v;
    logic [35:0] back_rx_d;
    logic mrst_n;
    logic prst_n;
  } host_state_t;

  host_state_t st_ff;
  host_state_t nxt_st;

  logic blk;
  logic a_mail_wr;
  logic a_fifo_wr;
  logic a_mail_rd;
  logic b_mail_wr;
  logic b_fifo_rd;
  logic b_mail_rd;

  assign blk = (st_ff.rt != RT_IDLE) || retransmit_start;
  assign a_mail_wr = st_ff.fwd_pend && link.fwd_mail_flag_n;
  assign a_fifo_wr = !a_mail_wr && send_valid && link.full_or_in_ready && !blk;
  assign a_mail_rd = !a_mail_wr && !a_fifo_wr && !link.back_mail_flag_n
                     && !st_ff.back_cap && !st_ff.back_rx_v;
  assign b_mail_wr = st_ff.back_pend && link.back_mail_flag_n;
  assign b_fifo_rd = !b_mail_wr && link.empty_or_out_ready && !st_ff.rd_cap
                     && (!st_ff.recv_v || recv_ready) && (st_ff.rt == RT_IDLE);
  assign b_mail_rd = !b_mail_wr && !b_fifo_rd && !link.fwd_mail_flag_n
                     && !st_ff.fwd_cap && !st_ff.fwd_rx_v;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.rd_cap = b_fifo_rd;
    nxt_st.fwd_cap = b_mail_rd;
    nxt_st.back_cap = a_mail_rd;
    nxt_st.mrst_n = 1'b1;
    nxt_st.prst_n = !flush_req;
    // Retransmit sequence: guard cycle, request low, recovery
    case (st_ff.rt)
      RT_IDLE: begin
        if (retransmit_start && !fall_through) begin
          nxt_st.rt = RT_GUARD;
        end
      end
      RT_GUARD: begin
        nxt_st.rt = RT_LOW;
        nxt_st.rt_cnt = fifo_link_pkg::RT_CNT_W'(fifo_link_pkg::RT_LOW_CYCLES - 1);
      end
      RT_LOW: begin
        if (st_ff.rt_cnt == '0) begin
          nxt_st.rt = RT_RECOVER;
          nxt_st.rt_cnt = fifo_link_pkg::RT_CNT_W'(fifo_link_pkg::RECOVERY_CYCLES
                                                   + fifo_link_pkg::FLAG_SETTLE_CYCLES - 1);
        end else begin
          nxt_st.rt_cnt = st_ff.rt_cnt - 1'b1;
        end
      end
      RT_RECOVER: begin
        if (st_ff.rt_cnt == '0) begin
          nxt_st.rt = RT_IDLE;
        end else begin
          nxt_st.rt_cnt = st_ff.rt_cnt - 1'b1;
        end
      end
      default: nxt_st.rt = RT_IDLE;
    endcase
    // Mail queued for sending
    if (a_mail_wr) begin
      nxt_st.fwd_pend = 1'b0;
    end else if (fwd_tx_valid && !st_ff.fwd_pend) begin
      nxt_st.fwd_pend = 1'b1;
      nxt_st.fwd_data = fwd_tx_data;
    end
    if (b_mail_wr) begin
      nxt_st.back_pend = 1'b0;
    end else if (back_tx_valid && !st_ff.back_pend) begin
      nxt_st.back_pend = 1'b1;
      nxt_st.back_data = back_tx_data;
    end
    // Capture read data one cycle after the read strobe
    if (st_ff.recv_v && recv_ready) begin
      nxt_st.recv_v = 1'b0;
    end
    if (st_ff.rd_cap) begin
      nxt_st.recv_v = 1'b1;
      nxt_st.recv_d = link.b_rd_data;
    end
    nxt_st.fwd_rx_v = st_ff.fwd_cap;
    if (st_ff.fwd_cap) begin
      nxt_st.fwd_rx_d = link.b_rd_data;
    end
    nxt_st.back_rx_v = st_ff.back_cap;
    if (st_ff.back_cap) begin
      nxt_st.back_rx_d = link.a_rd_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= '0;
      st_ff.prst_n <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Port A pins
  assign link.input_port_select_n = !(a_mail_wr || a_fifo_wr || a_mail_rd);
  assign link.input_port_direction = a_mail_wr || a_fifo_wr;
  assign link.input_mailbox_select = a_mail_wr || a_mail_rd;
  assign link.a_wr_data = a_mail_wr ? st_ff.fwd_data : send_data;
  // Port B pins
  assign link.output_port_select_n = !(b_mail_wr || b_fifo_rd || b_mail_rd);
  assign link.output_port_direction = b_fifo_rd || b_mail_rd;
  assign link.output_mailbox_select = b_mail_wr || b_mail_rd;
  assign link.b_wr_data = st_ff.back_data;
  // Control pins
  assign link.master_reset_n = st_ff.mrst_n;
  assign link.partial_reset_n = st_ff.prst_n;
  assign link.retransmit_req_n = (st_ff.rt != RT_LOW);
  assign link.fall_through_mode = fall_through;
  assign link.port_b_size = port_size;
  // User side
  assign send_ready = a_fifo_wr;
  assign recv_valid = st_ff.recv_v;
  assign recv_data = st_ff.recv_d;
  assign fwd_tx_ready = !st_ff.fwd_pend;
  assign fwd_rx_valid = st_ff.fwd_rx_v;
  assign fwd_rx_data = st_ff.fwd_rx_d;
  assign back_tx_ready = !st_ff.back_pend;
  assign back_rx_valid = st_ff.back_rx_v;
  assign back_rx_data = st_ff.back_rx_d;
  assign retransmit_busy = (st_ff.rt != RT_IDLE);
endmodule
`default_nettype wire

// [bench/fifo_link_sva.sv]
// Purpose: Assertions on the link between the FIFO device end and the host end
// Assumes: One clock; only interface signals are seen
// Notes: Shadow copies of both mailboxes hold the expected mail data
`timescale 1ns/1ps
`default_nettype none
module fifo_link_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Port A
  input wire logic input_port_select_n,
  input wire logic input_port_direction,
  input wire logic input_mailbox_select,
  input wire logic [35:0] a_wr_data,
  input wire logic [35:0] a_rd_data,
  // Port B
  input wire logic output_port_select_n,
  input wire logic output_port_direction,
  input wire logic output_mailbox_select,
  input wire logic [35:0] b_wr_data,
  input wire logic [35:0] b_rd_data,
  // Control
  input wire logic master_reset_n,
  input wire logic partial_reset_n,
  input wire logic retransmit_req_n,
  input wire fifo_link_pkg::port_size_t port_b_size,
  // Flags
  input wire logic full_or_in_ready,
  input wire logic empty_or_out_ready,
  input wire logic almost_empty_n,
  input wire logic almost_full_n,
  input wire logic fwd_mail_flag_n,
  input wire logic back_mail_flag_n
);
  typedef struct packed {
    logic [35:0] fwd;
    logic [35:0] back;
    logic [7:0] since_rt;
  } shadow_t;
  shadow_t st_ff;
  shadow_t nxt_st;
  logic a_wr, a_mw, a_mr, b_rd, b_mw, b_mr, live;
  logic [35:0] keep;
  assign a_wr = !input_port_select_n && input_port_direction && !input_mailbox_select;
  assign a_mw = !input_port_select_n && input_port_direction && input_mailbox_select;
  assign a_mr = !input_port_select_n && !input_port_direction && input_mailbox_select;
  assign b_rd = !output_port_select_n && output_port_direction && !output_mailbox_select;
  assign b_mr = !output_port_select_n && output_port_direction && output_mailbox_select;
  assign b_mw = !output_port_select_n && !output_port_direction && output_mailbox_select;
  assign live = master_reset_n && partial_reset_n;
  // Mail bits kept for the port B width
  assign keep = port_b_size == fifo_link_pkg::SIZE_WORD ? 36'h3ffff :
    port_b_size == fifo_link_pkg::SIZE_BYTE ? 36'h1ff : 36'hfffffffff;
  always_comb begin
    nxt_st = st_ff;
    if (a_mw) nxt_st.fwd = a_wr_data & keep;
    if (b_mw) nxt_st.back = b_wr_data & keep;
    if (!retransmit_req_n) nxt_st.since_rt = 8'h0;
    else if (st_ff.since_rt != 8'hff) nxt_st.since_rt = st_ff.since_rt + 8'h1;
  end
  always_ff @(posedge clk) begin
    if (!nrst) st_ff <= {72'h0, 8'hff};
    else st_ff <= nxt_st;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reset_flags: assert property (disable iff (1'b0)
    (!nrst || !live) |=> !almost_empty_n && almost_full_n && !full_or_in_ready
    && !empty_or_out_ready && fwd_mail_flag_n && back_mail_flag_n)
    else $error("flags not at reset levels");
  a_fwd_mail_set: assert property (a_mw && live |=> !fwd_mail_flag_n)
    else $error("forward mail flag not low after write");
  a_fwd_mail_read: assert property (b_mr && !a_mw && live |=>
    fwd_mail_flag_n && b_rd_data == st_ff.fwd) else $error("forward mail read wrong");
  a_back_mail_set: assert property (b_mw && live |=> !back_mail_flag_n)
    else $error("back mail flag not low after write");
  a_back_mail_read: assert property (a_mr && !b_mw && live |=>
    back_mail_flag_n && a_rd_data == st_ff.back) else $error("back mail read wrong");
  a_write_not_empty: assert property (a_wr && full_or_in_ready && live && retransmit_req_n
    |=> empty_or_out_ready) else $error("write left FIFO empty");
  a_rt_flags_frozen: assert property ((!retransmit_req_n || st_ff.since_rt < 8'h14) && live
    |=> $stable(almost_empty_n) && $stable(almost_full_n)) else $error("almost flags moved");
  a_idle_flags_hold: assert property (!a_wr && !b_rd && live && st_ff.since_rt > 8'h1e
    |=> $stable(almost_empty_n) && $stable(almost_full_n) && $stable(empty_or_out_ready))
    else $error("flags moved without traffic");
endmodule
`default_nettype wire

// [bench/dual_clock_fifo_flags_mailbox_retransmit_tb_top.sv]
// Purpose: Self-checking bench for the FIFO device end and host end
// Assumes: Fall-through mode held off until the final retransmit check; one clock
// Notes: Expected pieces are queued per port width by bench functions
`timescale 1ns/1ps
`default_nettype none
module dual_clock_fifo_flags_mailbox_retransmit_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  fifo_link_pkg::port_size_t port_size = fifo_link_pkg::SIZE_LONG;
  logic fall_through = 1'b0, flush_req = 1'b0, retransmit_start = 1'b0, send_valid = 1'b0;
  logic recv_ready = 1'b0, fwd_tx_valid = 1'b0, back_tx_valid = 1'b0;
  logic [35:0] send_data = 36'h0, fwd_tx_data = 36'h0, back_tx_data = 36'h0;
  logic retransmit_busy, send_ready, recv_valid, fwd_tx_ready, fwd_rx_valid;
  logic back_tx_ready, back_rx_valid;
  logic [35:0] recv_data, fwd_rx_data, back_rx_data;
  logic [35:0] exp_q[$];
  int n_errors = 0, checks = 0, seed = 32'hfdb8;
  always #2 clk = ~clk;
  fifo_link_if link();
  fifo_device_end fifo_device_end_inst (.clk(clk), .nrst(nrst), .link(link));
  fifo_host_end fifo_host_end_inst (.clk, .nrst, .port_size, .fall_through, .flush_req,
    .retransmit_start, .retransmit_busy, .send_valid, .send_ready, .send_data, .recv_valid,
    .recv_ready, .recv_data, .fwd_tx_valid, .fwd_tx_ready, .fwd_tx_data, .fwd_rx_valid,
    .fwd_rx_data, .back_tx_valid, .back_tx_ready, .back_tx_data, .back_rx_valid,
    .back_rx_data, .link(link));
  fifo_link_sva fifo_link_sva_inst (.clk(clk), .nrst(nrst),
    .input_port_select_n(link.input_port_select_n), .a_wr_data(link.a_wr_data),
    .input_port_direction(link.input_port_direction), .a_rd_data(link.a_rd_data),
    .input_mailbox_select(link.input_mailbox_select), .b_wr_data(link.b_wr_data),
    .output_port_select_n(link.output_port_select_n), .b_rd_data(link.b_rd_data),
    .output_port_direction(link.output_port_direction), .port_b_size(link.port_b_size),
    .output_mailbox_select(link.output_mailbox_select), .master_reset_n(link.master_reset_n),
    .partial_reset_n(link.partial_reset_n), .retransmit_req_n(link.retransmit_req_n),
    .full_or_in_ready(link.full_or_in_ready), .empty_or_out_ready(link.empty_or_out_ready),
    .almost_empty_n(link.almost_empty_n), .almost_full_n(link.almost_full_n),
    .fwd_mail_flag_n(link.fwd_mail_flag_n), .back_mail_flag_n(link.back_mail_flag_n));
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk({35'h0, got}, {35'h0, exp});
  endtask
  function automatic logic [35:0] rnd();
    return {4'($random(seed)), 32'($random(seed))};
  endfunction
  // One piece of a long word as port B delivers it
  function automatic logic [35:0] cut(input logic [35:0] d, input int i);
    if (port_size == fifo_link_pkg::SIZE_WORD) return (d >> (18 * i)) & 36'h3ffff;
    if (port_size == fifo_link_pkg::SIZE_BYTE) return (d >> (9 * i)) & 36'h1ff;
    return d;
  endfunction
  task automatic send(input int n);
    logic [35:0] d;
    int t;
    send_valid <= 1'b1;
    for (int k = 0; k < n; k++) begin
      d = k == 0 ? 36'hfffffffff : k == 1 ? 36'h0 : rnd();
      send_data <= d;
      for (int p = 0; p < (port_size == fifo_link_pkg::SIZE_BYTE ? 4 : port_size == 
        fifo_link_pkg::SIZE_WORD ? 2 : 1); p++) exp_q.push_back(cut(d, p));
      t = 0;
      do @(posedge clk); while (send_ready !== 1'b1 && ++t < 100);
    end
    send_valid <= 1'b0;
  endtask
  task automatic recv(input int n);
    int t;
    for (t = 0; n > 0 && t < 20000; t++) begin
      recv_ready <= ($random(seed) & 3) != 0;
      @(posedge clk);
      if (recv_valid === 1'b1 && recv_ready === 1'b1) begin
        chk(recv_data, exp_q.pop_front());
        n--;
      end
    end
    recv_ready <= 1'b0;
    chk(n, 0);
  endtask
  task automatic flush();
    flush_req <= 1'b1;
    repeat (4) @(posedge clk);
    flush_req <= 1'b0;
    repeat (4) @(posedge clk);
    exp_q.delete();
    chk_flag(link.almost_empty_n, 1'b0);
    chk_flag(link.empty_or_out_ready, 1'b0);
  endtask
  task automatic conclude();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    conclude();
  end
  initial begin
    logic [35:0] f, b, d;
    logic [35:0] keep_q[$];
    int idle, got;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int s = 0; s < 3; s++) begin
      port_size <= fifo_link_pkg::port_size_t'(s);
      flush();
      send(12);
      repeat (4) @(posedge clk);
      chk_flag(link.empty_or_out_ready, 1'b1);
      chk_flag(link.almost_empty_n, 1'b1);
      recv(exp_q.size());
      repeat (4) @(posedge clk);
      chk_flag(link.almost_empty_n, 1'b0);
      f = rnd();
      b = rnd();
      fwd_tx_valid <= 1'b1;
      fwd_tx_data <= f;
      back_tx_valid <= 1'b1;
      back_tx_data <= b;
      got = 0;
      for (int t = 0; t < 60; t++) begin
        @(posedge clk);
        if (fwd_tx_ready === 1'b1) fwd_tx_valid <= 1'b0;
        if (back_tx_ready === 1'b1) back_tx_valid <= 1'b0;
        if (fwd_rx_valid === 1'b1) chk(fwd_rx_data, cut(f, 0));
        if (back_rx_valid === 1'b1) chk(back_rx_data, cut(b, 0));
        got += (fwd_rx_valid === 1'b1) + (back_rx_valid === 1'b1);
      end
      chk(got, 2);
      chk_flag(link.fwd_mail_flag_n & link.back_mail_flag_n, 1'b1);
      $display("test stream and mail width %0d done", s);
    end
    port_size <= fifo_link_pkg::SIZE_LONG;
    flush();
    d = rnd();
    send_valid <= 1'b1;
    send_data <= d;
    idle = 0;
    for (int t = 0; t < 3000 && idle < 16; t++) begin
      @(posedge clk);
      if (send_ready === 1'b1) begin
        exp_q.push_back(d);
        d = rnd();
        send_data <= d;
        idle = 0;
      end else idle++;
    end
    send_valid <= 1'b0;
    chk_flag(exp_q.size() >= fifo_link_pkg::DEPTH_DEFAULT, 1'b1);
    chk_flag(link.full_or_in_ready, 1'b0);
    chk_flag(link.almost_full_n, 1'b0);
    recv(exp_q.size());
    chk_flag(link.almost_full_n, 1'b1);
    $display("test fill and drain done");
    flush();
    send(12);
    keep_q = exp_q;
    recv(exp_q.size());
    exp_q = keep_q;
    retransmit_start <= 1'b1;
    @(posedge clk);
    retransmit_start <= 1'b0;
    @(posedge clk);
    send_valid <= 1'b1;
    for (int t = 0; t < 10; t++) begin
      @(posedge clk);
      chk_flag(send_ready, 1'b0);
    end
    send_valid <= 1'b0;
    for (int t = 0; t < 200 && retransmit_busy !== 1'b0; t++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk_flag(link.empty_or_out_ready, 1'b1);
    chk_flag(link.almost_empty_n, 1'b1);
    recv(exp_q.size());
    // Fall-through mode must leave a retransmit request unanswered
    fall_through <= 1'b1;
    retransmit_start <= 1'b1;
    @(posedge clk);
    retransmit_start <= 1'b0;
    @(posedge clk);
    chk_flag(retransmit_busy, 1'b0);
    chk_flag(link.retransmit_req_n, 1'b1);
    $display("test retransmit done");
    conclude();
  end
endmodule
`default_nettype wire
